// ===== hdl/dma_master.sv
`timescale 1ns/1ns
module dma_master
	import dram_dma_pkg::*;
#(
	parameter bit DUAL_PORT = 1'b0,
	parameter int DEPTH     = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst,
	// Command from user
	input  wire logic                   i_cmd_valid,
	output logic                        o_cmd_ready,
	input  wire logic                   i_cmd_wr,
	input  wire logic [1:0]             i_cmd_size,
	input  wire logic [BYTE_ADDR_W-1:0] i_cmd_addr,
	input  wire logic [DATA_W-1:0]      i_cmd_wdata,
	// Read words to user
	output logic                        o_rd_valid,
	input  wire logic                   i_rd_ready,
	output logic      [DATA_W-1:0]      o_rd_data,
	// Device side
	dram_dma_if.dma                     dma
);
	typedef enum logic [1:0] {M_IDLE, M_HALT, M_XFER, M_WAIT} mstate_type;
	typedef struct packed {
		mstate_type             st;
		logic                   wr;
		logic [1:0]             size;
		logic [BYTE_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]      wdata;
	} state_type;
	state_type s_q;
	state_type s_d;
	logic      f_in_ready;
	logic      push_rd;

	// Read words buffered; full buffer holds off new reads
	word_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) i_word_fifo (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_in_valid  (push_rd),
		.o_in_ready  (f_in_ready),
		.i_in_data   (dma.xfer_rd_word),
		.o_out_valid (o_rd_valid),
		.i_out_ready (i_rd_ready),
		.o_out_data  (o_rd_data)
	);
	assign push_rd     = s_q.st == M_WAIT && dma.xfer_done && !s_q.wr;
	assign o_cmd_ready = s_q.st == M_IDLE && f_in_ready;

	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			M_IDLE:
				if (i_cmd_valid && f_in_ready)
				begin
					s_d.wr    = i_cmd_wr;
					s_d.size  = i_cmd_size;
					s_d.addr  = i_cmd_addr; // R9
					s_d.wdata = i_cmd_wdata;
					s_d.st    = DUAL_PORT ? M_XFER : M_HALT;
				end
			M_HALT:
				if (dma.core_halted_ack) // R17
					s_d.st = M_XFER;
			M_XFER:
				s_d.st = M_WAIT;
			M_WAIT:
				if (dma.xfer_done)
					s_d.st = M_IDLE;
			default:
				s_d.st = M_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Request one cycle; single-port holds halt from command until done, dual-port never halts
	assign dma.xfer_req_n     = s_q.st != M_XFER; // R12
	assign dma.xfer_port_on   = s_q.st != M_IDLE; // R10
	assign dma.core_halt_req  = !DUAL_PORT && s_q.st != M_IDLE; // R16 R18
	assign dma.xfer_dir       = s_q.wr ? DIR_WRITE : DIR_READ; // R13
	assign dma.xfer_size      = s_q.size; // R11
	assign dma.xfer_byte_addr = s_q.addr;
	assign dma.xfer_wr_word   = s_q.wdata; // R15
endmodule // dma_master

// ===== hdl/dram_port.sv
`timescale 1ns/1ns
module dram_port
	import dram_dma_pkg::*;
#(
	parameter bit DUAL_PORT = 1'b0
) (
	// Clock and reset
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst,
	// DMA side
	dram_dma_if.device                  dma,
	// Core access
	input  wire logic                   i_core_req,
	input  wire logic                   i_core_wr,
	input  wire logic [WORD_ADDR_W-1:0] i_core_addr,
	input  wire logic [DATA_W-1:0]      i_core_wdata,
	input  wire logic [BE_W-1:0]        i_core_be,
	output logic      [DATA_W-1:0]      o_core_rdata,
	output logic                        o_core_stall,
	// Primary RAM port
	output logic      [WORD_ADDR_W-1:0] o_ram_word_addr,
	output logic                        o_ram_chip_sel,
	input  wire logic [DATA_W-1:0]      i_ram_rd_word,
	output logic      [DATA_W-1:0]      o_ram_wr_word,
	output logic      [BE_W-1:0]        o_ram_byte_we,
	// Second RAM port
	output logic      [WORD_ADDR_W-1:0] o_port2_word_addr,
	output logic                        o_port2_chip_sel,
	input  wire logic [DATA_W-1:0]      i_port2_rd_word,
	output logic      [DATA_W-1:0]      o_port2_wr_word,
	output logic      [BE_W-1:0]        o_port2_byte_we
);
	typedef enum logic [1:0] {ST_RUN, ST_HALTED, ST_READ} mode_type;
	typedef struct packed {
		mode_type                mode;
		logic                    rd_pend;
		logic                    rd_port2;
		logic [DATA_W-1:0]       rd_word;
		logic                    done;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic      dma_go;
	logic      dma_wr;
	logic      shared;
	logic [BE_W-1:0] lane_mask;

	// ----------------------------------------------------------------
	// Byte lanes for narrow writes
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (dma.xfer_size) // R11
			SIZE_BYTE: lane_mask = 4'h1 << dma.xfer_byte_addr[1:0]; // R20
			SIZE_HALF: lane_mask = dma.xfer_byte_addr[1] ? 4'hc : 4'h3;
			SIZE_WORD: lane_mask = BE_ALL;
			default:   lane_mask = BE_NONE; // Reserved size writes nothing
		endcase
	end

	// Request only counts while the port is on; shared path needs halt
	assign dma_go = !dma.xfer_req_n && dma.xfer_port_on; // R10 R12
	assign dma_wr = dma.xfer_dir == DIR_WRITE; // R13
	assign shared = !DUAL_PORT && s_q.mode == ST_HALTED; // R3

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		s_d.rd_pend = 1'b0;
		if (s_q.rd_pend)
		begin
			s_d.rd_word = s_q.rd_port2 ? i_port2_rd_word
			                           : i_ram_rd_word; // R14
			s_d.done = 1'b1;
		end
		case (s_q.mode)
			ST_RUN:
				if (!DUAL_PORT && dma.core_halt_req)
					s_d.mode = ST_HALTED; // R16
			ST_HALTED:
				if (!dma.core_halt_req)
					s_d.mode = ST_RUN; // R21
			default:
				s_d.mode = ST_RUN;
		endcase
		if ((shared || DUAL_PORT) && dma_go && !s_q.rd_pend)
		begin
			s_d.rd_pend  = !dma_wr; // R13
			s_d.rd_port2 = DUAL_PORT;
			s_d.done     = dma_wr;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			s_q      <= '0; // R19
			s_q.mode <= ST_RUN;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// RAM ports
	// ----------------------------------------------------------------
	logic dma_cycle;
	assign dma_cycle = dma_go && !s_q.rd_pend;

	always_comb
	begin
		// R4 R7
		if (shared) // R3
		begin
			o_ram_word_addr = dma.xfer_byte_addr[BYTE_ADDR_W-1:2];
			o_ram_chip_sel  = dma_cycle; // R5
			o_ram_wr_word   = dma.xfer_wr_word; // R15
			o_ram_byte_we   = (dma_cycle && dma_wr) ? lane_mask : BE_NONE; // R6
		end
		else
		begin
			o_ram_word_addr = i_core_addr;
			o_ram_chip_sel  = i_core_req && !o_core_stall; // R5
			o_ram_wr_word   = i_core_wdata;
			o_ram_byte_we   = (o_ram_chip_sel && i_core_wr) ? i_core_be
			                                               : BE_NONE; // R6
		end
		// R8 R2
		o_port2_word_addr = dma.xfer_byte_addr[BYTE_ADDR_W-1:2];
		o_port2_chip_sel  = DUAL_PORT && dma_cycle;
		o_port2_wr_word   = dma.xfer_wr_word;
		o_port2_byte_we   = (o_port2_chip_sel && dma_wr) ? lane_mask : BE_NONE;
	end

	assign o_core_stall        = s_q.mode == ST_HALTED; // R1
	assign o_core_rdata        = i_ram_rd_word;
	assign dma.core_halted_ack = s_q.mode == ST_HALTED; // R17
	assign dma.xfer_rd_word    = s_q.rd_word; // R14
	assign dma.xfer_done       = s_q.done;
endmodule // dram_port

// ===== hdl/word_fifo.sv
`timescale 1ns/1ns
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      cnt_q;
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem_q[rd_q];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_q[wr_q] <= i_in_data;
		if (i_rst)
		begin
			cnt_q <= '0;
			wr_q  <= '0;
			rd_q  <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // word_fifo

// ===== include/dram_dma_if.sv
`timescale 1ns/1ns
interface dram_dma_if;
	import dram_dma_pkg::*;
	logic [BYTE_ADDR_W-1:0] xfer_byte_addr;
	logic [DATA_W-1:0]      xfer_wr_word;
	logic                   xfer_port_on;
	logic [1:0]             xfer_size;
	logic                   xfer_req_n;
	logic                   xfer_dir;
	logic [DATA_W-1:0]      xfer_rd_word;
	logic                   core_halted_ack;
	logic                   core_halt_req;
	logic                   xfer_done;

	modport device (
		input  xfer_byte_addr, xfer_wr_word, xfer_port_on, xfer_size,
		input  xfer_req_n, xfer_dir, core_halt_req,
		output xfer_rd_word, core_halted_ack, xfer_done
	);
	modport dma (
		output xfer_byte_addr, xfer_wr_word, xfer_port_on, xfer_size,
		output xfer_req_n, xfer_dir, core_halt_req,
		input  xfer_rd_word, core_halted_ack, xfer_done
	);
endinterface

// ===== include/dram_dma_pkg.sv
// Contract
// R1: Single-port DMA halts core execution.
// R2: Dual-port DMA runs without core stall.
// R3: Single-port DMA reuses core RAM signals.
// R4: RAM address is 24-bit word address.
// R5: Chip select high whenever bus used.
// R6: Byte enables gate one lane each.
// R7: RAM read and write data 32 bits.
// R8: Dual-port: separate second port for DMA.
// R9: Master gives 26-bit byte address, unused low.
// R10: Transfer proceeds only while port enabled.
// R11: Size 00 byte, 01 half, 10 word.
// R12: Request is active low, idle high.
// R13: Direction 0 read, 1 write.
// R14: DMA read word on dedicated output.
// R15: DMA write word on 32-bit input.
// R16: Wait request stalls core before transfer.
// R17: Ready high once core halted.
// R18: Wait request tied low for dual-port.
// R19: Reset returns port and handshake idle.
// R20: Narrow writes enable only selected bytes.
// R21: Wait removed: drop ready, core resumes.
package dram_dma_pkg;
	// ----------------------------------------------------------------
	// Widths and encodings
	// ----------------------------------------------------------------
	localparam int WORD_ADDR_W = 24;
	localparam int BYTE_ADDR_W = 26;
	localparam int DATA_W      = 32;
	localparam int BE_W        = 4;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic       DIR_READ  = 1'h0;
	localparam logic       DIR_WRITE = 1'h1;
	localparam int FIFO_DEPTH  = 8;
	localparam logic [3:0] BE_NONE   = 4'h0;
	localparam logic [3:0] BE_ALL    = 4'hf;
endpackage

// ===== testbench/data_ram_port_with_dma_access_test.sv
`timescale 1ns/1ns
module data_ram_port_with_dma_access_test;
	import dram_dma_pkg::*;
	logic        i_mclk, i_rst, cv, cr, cw, rv, rr;
	logic        creq, cwr, stall, csel;
	logic [1:0]  csz;
	logic [25:0] ca;
	logic [31:0] cd, rd, rq, wwd, crd, cwd;
	logic [23:0] cad, rad;
	logic [3:0]  cbe, rwe;
	logic [31:0] mem [0:15];
	int          errors, comparisons;
	dram_dma_if bus ();

	dram_port #(.DUAL_PORT(1'b0)) i_dram_port (.i_mclk(i_mclk), .i_rst(i_rst),
		.dma(bus), .i_core_req(creq), .i_core_wr(cwr), .i_core_addr(cad),
		.i_core_wdata(cwd), .i_core_be(cbe), .o_core_rdata(crd),
		.o_core_stall(stall), .o_ram_word_addr(rad), .o_ram_chip_sel(csel),
		.i_ram_rd_word(rq), .o_ram_wr_word(wwd), .o_ram_byte_we(rwe),
		.o_port2_word_addr(), .o_port2_chip_sel(), .i_port2_rd_word(32'h0),
		.o_port2_wr_word(), .o_port2_byte_we());
	dma_master #(.DUAL_PORT(1'b0), .DEPTH(FIFO_DEPTH)) i_dma_master (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd_valid(cv), .o_cmd_ready(cr),
		.i_cmd_wr(cw), .i_cmd_size(csz), .i_cmd_addr(ca), .i_cmd_wdata(cd),
		.o_rd_valid(rv), .i_rd_ready(rr), .o_rd_data(rd), .dma(bus));
	dram_dma_checker i_dram_dma_checker (.i_mclk(i_mclk), .i_rst(i_rst),
		.xfer_req_n(bus.xfer_req_n), .xfer_dir(bus.xfer_dir),
		.xfer_size(bus.xfer_size), .xfer_port_on(bus.xfer_port_on),
		.core_halt_req(bus.core_halt_req),
		.core_halted_ack(bus.core_halted_ack), .xfer_done(bus.xfer_done));

	// ---
	// RAM model, one cycle read latency
	// ---
	always @(posedge i_mclk)
		if (csel)
		begin
			for (int b = 0; b < 4; b++)
				if (rwe[b])
					mem[rad[3:0]][8*b+:8] <= wwd[8*b+:8];
			rq <= mem[rad[3:0]];
		end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cmd(input logic w, input logic [1:0] s, input logic [25:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		while (cr !== 1'b1 && n < 50)
		begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 50)
		begin
			errors++;
			$display("ERROR %0t: command not accepted", $time);
		end
		{cw, csz, ca, cd, cv} = {w, s, a, d, 1'b1};
		@(negedge i_mclk);
		cv = 1'b0;
	endtask

	task dma_wr(input logic [25:0] a, input logic [1:0] s, input logic [31:0] d);
		int n;
		n = 0;
		cmd(1'b1, s, a, d);
		while (bus.xfer_done !== 1'b1 && n < 30)
		begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 30)
		begin
			errors++;
			$display("ERROR %0t: write never done", $time);
		end
		chk({31'h0, stall}, 32'h1);
		@(negedge i_mclk);
	endtask

	task pop(input logic [31:0] exp);
		int n;
		n = 0;
		rr = 1'b1;
		while (rv !== 1'b1 && n < 30)
		begin
			@(negedge i_mclk);
			n++;
		end
		if (n >= 30)
		begin
			errors++;
			$display("ERROR %0t: read word never arrived", $time);
		end
		chk(rd, exp);
		@(negedge i_mclk);
	endtask

	task t_sizes;
		dma_wr(26'h10, SIZE_WORD, 32'h11223344);
		cmd(1'b0, SIZE_WORD, 26'h10, 32'h0);
		pop(32'h11223344);
		dma_wr(26'h11, SIZE_BYTE, 32'h5a5a5a5a);
		dma_wr(26'h12, SIZE_HALF, 32'h96969696);
		cmd(1'b0, SIZE_WORD, 26'h10, 32'h0);
		pop(32'h96965a44);
	endtask

	task t_core;
		{creq, cwr, cad, cwd, cbe} = {2'h3, 24'h3, 32'hc0ffee00, 4'hf};
		#1;
		chk({7'h0, csel, rad}, {8'h1, 24'h3});
		chk(wwd, 32'hc0ffee00);
		chk({28'h0, rwe}, 32'hf);
		@(negedge i_mclk);
		creq = 1'b0;
		cmd(1'b0, SIZE_WORD, 26'hc, 32'h0);
		pop(32'hc0ffee00);
		repeat (4) @(negedge i_mclk);
		chk({30'h0, stall, bus.core_halted_ack}, 32'h0);
	endtask

	task t_fifo;
		rr = 1'b0;
		repeat (FIFO_DEPTH) cmd(1'b0, SIZE_WORD, 26'h10, 32'h0);
		repeat (20) @(negedge i_mclk);
		chk({31'h0, cr}, 32'h0);
		repeat (FIFO_DEPTH) pop(32'h96965a44);
		chk({31'h0, rv}, 32'h0);
	endtask

	task end_sim;
		if (errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	initial
	begin
		#200000;
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		end_sim();
	end

	initial
	begin
		for (int k = 0; k < 16; k++)
			mem[k] = 32'h0;
		{i_rst, cv, cw, csz, ca, cd, rr} = {1'b1, 62'h0, 1'b1};
		{creq, cwr, cad, cwd, cbe} = 62'h0;
		repeat (12) @(negedge i_mclk);
		i_rst = 1'b0;
		t_sizes();
		t_core();
		t_fifo();
		end_sim();
	end
endmodule // data_ram_port_with_dma_access_test

// ===== testbench/dram_dma_checker.sv
`timescale 1ns/1ns
module dram_dma_checker (
	// Clock and reset
	input wire logic       i_mclk,
	input wire logic       i_rst,
	// Interface signals
	input wire logic       xfer_req_n,
	input wire logic       xfer_dir,
	input wire logic [1:0] xfer_size,
	input wire logic       xfer_port_on,
	input wire logic       core_halt_req,
	input wire logic       core_halted_ack,
	input wire logic       xfer_done
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	ack_cause_a: assert property ($rose(core_halted_ack) |-> $past(core_halt_req))
		else $error("ack without halt request");
	ack_drop_a: assert property (!core_halt_req && core_halted_ack |=> !core_halted_ack)
		else $error("ack held after halt request dropped");
	xfer_halt_a: assert property (!xfer_req_n |-> core_halted_ack)
		else $error("transfer before core halted");
	xfer_on_a: assert property (!xfer_req_n |-> xfer_port_on)
		else $error("transfer with port disabled");
	wr_done_a: assert property (!xfer_req_n && xfer_dir |=> xfer_done)
		else $error("write not done next cycle");
	rd_done_a: assert property (!xfer_req_n && !xfer_dir |=> !xfer_done ##1 xfer_done)
		else $error("read done at wrong cycle");
	done_pulse_a: assert property (xfer_done |=> !xfer_done)
		else $error("done longer than one cycle");
	size_legal_a: assert property (!xfer_req_n && xfer_dir |-> xfer_size != 2'h3)
		else $error("reserved size on write");
	reset_idle_a: assert property (@(posedge i_mclk) disable iff (1'b0)
		i_rst |=> xfer_req_n && !core_halt_req && !core_halted_ack && !xfer_done)
		else $error("not idle after reset");

	cover property (!xfer_req_n && xfer_dir);
	cover property (!xfer_req_n && !xfer_dir);
	cover property ($fell(core_halted_ack));
endmodule // dram_dma_checker
